// ==== core/d8pt_channel.sv ====
`include "d8pt_regs.svh"
`default_nettype none
module d8pt_channel (
    input wire logic clock,
    input wire logic resetn,
    input wire logic tick,
    input wire logic reload_strobe,
    input wire d8pt_pkg::d8pt_byte_t reload_value,
    output d8pt_pkg::d8pt_chan_stat_s stat
);
    typedef struct packed {
        logic [7:0] count;
    } d8pt_ch_state_s;
    d8pt_ch_state_s s_q, s_d;
    always_comb begin
        s_d = s_q;
        stat.underflow = 1'b0;
        if (reload_strobe) begin
            s_d.count = reload_value;
        end else if (tick) begin
            if (s_q.count == 8'h00) begin
                s_d.count = reload_value;
                stat.underflow = 1'b1;
            end else begin
                s_d.count = s_q.count - 8'h01;
            end
        end
        stat.count = s_q.count;
    end
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s_q.count <= `D8PT_COUNT_RST;
        end else begin
            s_q <= s_d;
        end
    end
    AST_CH_HOLD: assert property (
        @(posedge clock) disable iff (!resetn)
        (!tick && !reload_strobe) |=> $stable(s_q.count))
        else $error("counter moved without a tick");
    AST_CH_RELOAD: assert property (
        @(posedge clock) disable iff (!resetn)
        reload_strobe |=> s_q.count == $past(reload_value))
        else $error("reload strobe did not preset");
    AST_CH_UNDER: assert property (
        @(posedge clock) disable iff (!resetn)
        (tick && !reload_strobe && s_q.count == 8'h00)
        |=> s_q.count == $past(reload_value))
        else $error("underflow did not reload");
endmodule
`default_nettype wire

// ==== core/d8pt_pkg.sv ====
`default_nettype none
package d8pt_pkg;
    typedef logic [7:0] d8pt_byte_t;
    typedef logic [1:0] d8pt_ratio_t;
    // per-channel software controls
    typedef struct packed {
        logic run_bit;
        logic reload_strobe;
        logic source_select;
        d8pt_ratio_t ratio;
        d8pt_byte_t reload_value;
    } d8pt_chan_ctrl_s;
    // per-channel readback
    typedef struct packed {
        d8pt_byte_t count;
        logic underflow;
    } d8pt_chan_stat_s;
endpackage
`default_nettype wire

// ==== core/d8pt_prescaler.sv ====
`include "d8pt_regs.svh"
`default_nettype none
module d8pt_prescaler (
    input wire logic clock,
    input wire logic resetn,
    input wire logic run_bit,
    input wire logic source_select,
    input wire logic low_speed_osc,
    input wire logic high_speed_osc,
    input wire d8pt_pkg::d8pt_ratio_t ratio,
    output logic tick
);
    typedef struct packed {
        logic [7:0] cnt;
    } d8pt_ps_state_s;
    d8pt_ps_state_s s_q, s_d;
    logic src;
    logic [7:0] lim;
    always_comb begin
        src = source_select ? high_speed_osc : low_speed_osc;
        unique case (ratio)
            `D8PT_RATIO_DIV1: lim = 8'h00;
            `D8PT_RATIO_DIV4: lim = `D8PT_PS_MAX4;
            `D8PT_RATIO_DIV32: lim = `D8PT_PS_MAX32;
            `D8PT_RATIO_DIV256: lim = `D8PT_PS_MAX256;
        endcase
        s_d = s_q;
        tick = 1'b0;
        // source enable pulses counted only while running
        if (run_bit && src) begin
            if (s_q.cnt >= lim) begin
                s_d.cnt = `D8PT_PS_RST;
                tick = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + 8'h01;
            end
        end
    end
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    AST_PS_IDLE: assert property (
        @(posedge clock) disable iff (!resetn)
        !run_bit |-> !tick)
        else $error("prescaler ticked while stopped");
    AST_PS_DIV1: assert property (
        @(posedge clock) disable iff (!resetn)
        (run_bit && src && ratio == 2'h0) |-> tick)
        else $error("divide by one missed a tick");
endmodule
`default_nettype wire

// ==== core/d8pt_regs.svh ====
`ifndef D8PT_REGS_SVH
`define D8PT_REGS_SVH
// prescaler ratio codes
`define D8PT_RATIO_DIV1 2'h0
`define D8PT_RATIO_DIV4 2'h1
`define D8PT_RATIO_DIV32 2'h2
`define D8PT_RATIO_DIV256 2'h3
// divide counts minus one
`define D8PT_PS_MAX4 8'h03
`define D8PT_PS_MAX32 8'h1f
`define D8PT_PS_MAX256 8'hff
// reset values
`define D8PT_COUNT_RST 8'h00
`define D8PT_PS_RST 8'h00
`endif

// ==== core/d8pt_timer.sv ====
`include "d8pt_regs.svh"
`default_nettype none
module d8pt_timer (
    input wire logic clock,
    input wire logic resetn,
    // oscillators arrive as one-cycle enable pulses
    input wire logic low_speed_osc,
    input wire logic high_speed_osc,
    input wire d8pt_pkg::d8pt_chan_ctrl_s t0_ctrl,
    input wire d8pt_pkg::d8pt_chan_ctrl_s t1_ctrl,
    input wire logic t0_counter_mode_sel,
    input wire logic t0_irq_mask,
    input wire logic t1_irq_mask,
    input wire logic wave_channel_select,
    input wire logic wave_output_enable,
    input wire logic t0_flag_clear,
    input wire logic t1_flag_clear,
    input wire logic t0_read_low,
    input wire logic t1_read_low,
    output logic [3:0] t0_count_readback_lo,
    output logic [3:0] t0_count_readback_hi,
    output logic [3:0] t1_count_readback_lo,
    output logic [3:0] t1_count_readback_hi,
    output logic t0_underflow_flag,
    output logic t1_underflow_flag,
    output logic irq,
    output logic square_wave_signal,
    output logic shared_port_pin,
    output logic serial_clock_pulse
);
    typedef struct packed {
        logic [3:0] t0_lo;
        logic [3:0] t0_hi;
        logic [3:0] t1_lo;
        logic [3:0] t1_hi;
        logic t0_flag;
        logic t1_flag;
        logic irq;
        logic wave;
        logic pin;
        logic ser;
    } d8pt_top_state_s;
    d8pt_top_state_s s_q, s_d;
    logic t0_tick, t1_tick;
    d8pt_pkg::d8pt_chan_stat_s t0_stat, t1_stat;
    logic t0_run_bit, t1_run_bit;
    logic sel_uf;

    // counter mode other than zero is a software fault; left undefined
    assign t0_run_bit = t0_ctrl.run_bit;
    assign t1_run_bit = t1_ctrl.run_bit;

    d8pt_prescaler u_ps0 (
        .clock(clock),
        .resetn(resetn),
        .run_bit(t0_run_bit),
        .source_select(t0_ctrl.source_select),
        .low_speed_osc(low_speed_osc),
        .high_speed_osc(high_speed_osc),
        .ratio(t0_ctrl.ratio),
        .tick(t0_tick)
    );
    d8pt_prescaler u_ps1 (
        .clock(clock),
        .resetn(resetn),
        .run_bit(t1_run_bit),
        .source_select(t1_ctrl.source_select),
        .low_speed_osc(low_speed_osc),
        .high_speed_osc(high_speed_osc),
        .ratio(t1_ctrl.ratio),
        .tick(t1_tick)
    );
    d8pt_channel u_ch0 (
        .clock(clock),
        .resetn(resetn),
        .tick(t0_tick),
        .reload_strobe(t0_ctrl.reload_strobe),
        .reload_value(t0_ctrl.reload_value),
        .stat(t0_stat)
    );
    d8pt_channel u_ch1 (
        .clock(clock),
        .resetn(resetn),
        .tick(t1_tick),
        .reload_strobe(t1_ctrl.reload_strobe),
        .reload_value(t1_ctrl.reload_value),
        .stat(t1_stat)
    );

    always_comb begin
        s_d = s_q;
        // low nibble tracks live; high only latched on a low read
        s_d.t0_lo = t0_stat.count[3:0];
        s_d.t1_lo = t1_stat.count[3:0];
        if (t0_read_low) begin
            s_d.t0_hi = t0_stat.count[7:4];
        end
        if (t1_read_low) begin
            s_d.t1_hi = t1_stat.count[7:4];
        end
        // set beats a clear in the same cycle
        if (t0_flag_clear) begin
            s_d.t0_flag = 1'b0;
        end
        if (t0_stat.underflow) begin
            s_d.t0_flag = 1'b1;
        end
        if (t1_flag_clear) begin
            s_d.t1_flag = 1'b0;
        end
        if (t1_stat.underflow) begin
            s_d.t1_flag = 1'b1;
        end
        s_d.irq = (s_d.t0_flag & t0_irq_mask)
                | (s_d.t1_flag & t1_irq_mask);
        sel_uf = wave_channel_select ? t1_stat.underflow
                                     : t0_stat.underflow;
        if (sel_uf) begin
            s_d.wave = ~s_q.wave;
        end
        // ungated toward the wave: enabling mid-cycle gives a short pulse
        s_d.pin = wave_output_enable ? s_d.wave : 1'b1;
        s_d.ser = t1_stat.underflow;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
            s_q.pin <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign t0_count_readback_lo = s_q.t0_lo;
    assign t0_count_readback_hi = s_q.t0_hi;
    assign t1_count_readback_lo = s_q.t1_lo;
    assign t1_count_readback_hi = s_q.t1_hi;
    assign t0_underflow_flag = s_q.t0_flag;
    assign t1_underflow_flag = s_q.t1_flag;
    assign irq = s_q.irq;
    assign square_wave_signal = s_q.wave;
    assign shared_port_pin = s_q.pin;
    assign serial_clock_pulse = s_q.ser;

    // flag steps: an underflow, a clear alone, and both at once
    sequence uf0_s;
        t0_stat.underflow;
    endsequence

    sequence uf1_s;
        t1_stat.underflow;
    endsequence

    sequence clr0_only_s;
        t0_flag_clear && !t0_stat.underflow;
    endsequence

    sequence clr1_only_s;
        t1_flag_clear && !t1_stat.underflow;
    endsequence

    sequence clash0_s;
        t0_flag_clear && t0_stat.underflow;
    endsequence

    // wave steps: which underflow feeds the divider this cycle
    sequence wave_uf0_s;
        !wave_channel_select && t0_stat.underflow;
    endsequence

    sequence wave_uf1_s;
        wave_channel_select && t1_stat.underflow;
    endsequence

    sequence wave_quiet_s;
        !(wave_channel_select ? t1_stat.underflow : t0_stat.underflow);
    endsequence

    AST_FLAG_SET: assert property (
        @(posedge clock) disable iff (!resetn)
        uf0_s |=> t0_underflow_flag)
        else $error("flag not set after underflow");

    AST_FLAG1_SET: assert property (
        @(posedge clock) disable iff (!resetn)
        uf1_s |=> t1_underflow_flag)
        else $error("timer 1 flag not set after underflow");

    AST_SET_WINS: assert property (
        @(posedge clock) disable iff (!resetn)
        clash0_s |=> t0_underflow_flag)
        else $error("clear beat a simultaneous underflow");

    AST_CLR0: assert property (
        @(posedge clock) disable iff (!resetn)
        clr0_only_s |=> !t0_underflow_flag)
        else $error("timer 0 flag not cleared");

    AST_CLR1: assert property (
        @(posedge clock) disable iff (!resetn)
        clr1_only_s |=> !t1_underflow_flag)
        else $error("timer 1 flag not cleared");

    AST_FLAG0_HOLD: assert property (
        @(posedge clock) disable iff (!resetn)
        (!t0_flag_clear && !t0_stat.underflow) |=> $stable(t0_underflow_flag))
        else $error("timer 0 flag moved by itself");

    AST_FLAG1_HOLD: assert property (
        @(posedge clock) disable iff (!resetn)
        (!t1_flag_clear && !t1_stat.underflow) |=> $stable(t1_underflow_flag))
        else $error("timer 1 flag moved by itself");

    AST_IRQ_MASK: assert property (
        @(posedge clock) disable iff (!resetn)
        (t1_underflow_flag && !t1_irq_mask && !t0_underflow_flag) |-> !irq)
        else $error("masked flag raised irq");

    AST_IRQ0_SET: assert property (
        @(posedge clock) disable iff (!resetn)
        (uf0_s ##0 t0_irq_mask) |=> irq)
        else $error("unmasked timer 0 underflow gave no irq");

    AST_IRQ1_SET: assert property (
        @(posedge clock) disable iff (!resetn)
        (uf1_s ##0 t1_irq_mask) |=> irq)
        else $error("unmasked timer 1 underflow gave no irq");

    AST_WAVE: assert property (
        @(posedge clock) disable iff (!resetn)
        wave_uf1_s |=> square_wave_signal != $past(square_wave_signal))
        else $error("wave missed toggle");

    AST_WAVE0: assert property (
        @(posedge clock) disable iff (!resetn)
        wave_uf0_s |=> square_wave_signal != $past(square_wave_signal))
        else $error("wave missed timer 0 toggle");

    AST_WAVE_HOLD: assert property (
        @(posedge clock) disable iff (!resetn)
        wave_quiet_s |=> $stable(square_wave_signal))
        else $error("wave toggled on the unselected channel");

    AST_PIN_HIGH: assert property (
        @(posedge clock) disable iff (!resetn)
        !wave_output_enable |=> shared_port_pin)
        else $error("pin not high while disabled");

    AST_PIN_WAVE: assert property (
        @(posedge clock) disable iff (!resetn)
        wave_output_enable |=> shared_port_pin == square_wave_signal)
        else $error("pin does not follow the wave");

    AST_SER: assert property (
        @(posedge clock) disable iff (!resetn)
        uf1_s |=> serial_clock_pulse)
        else $error("serial clock pulse missing");

    AST_SER_ONLY: assert property (
        @(posedge clock) disable iff (!resetn)
        !t1_stat.underflow |=> !serial_clock_pulse)
        else $error("serial clock pulse without underflow");

    AST_HI_HOLD: assert property (
        @(posedge clock) disable iff (!resetn)
        !t0_read_low |=> $stable(t0_count_readback_hi))
        else $error("latched high nibble moved");

    AST_HI1_HOLD: assert property (
        @(posedge clock) disable iff (!resetn)
        !t1_read_low |=> $stable(t1_count_readback_hi))
        else $error("timer 1 latched high nibble moved");

    AST_HI_LATCH: assert property (
        @(posedge clock) disable iff (!resetn)
        t0_read_low |=> t0_count_readback_hi == $past(t0_stat.count[7:4]))
        else $error("timer 0 high nibble not latched");

    AST_HI1_LATCH: assert property (
        @(posedge clock) disable iff (!resetn)
        t1_read_low |=> t1_count_readback_hi == $past(t1_stat.count[7:4]))
        else $error("timer 1 high nibble not latched");

    AST_UF_AT_ZERO: assert property (
        @(posedge clock) disable iff (!resetn)
        uf0_s |-> t0_tick && t0_stat.count == 8'h00)
        else $error("underflow away from zero");

    AST_STOP_NO_UF: assert property (
        @(posedge clock) disable iff (!resetn)
        !t0_run_bit |-> !t0_stat.underflow)
        else $error("stopped timer 0 underflowed");

    AST_STOP_NO_UF1: assert property (
        @(posedge clock) disable iff (!resetn)
        !t1_run_bit |-> !t1_stat.underflow)
        else $error("stopped timer 1 underflowed");
endmodule
`default_nettype wire

// ==== testbench/d8pt_partner.sv ====
`default_nettype none
module d8pt_partner (
    input wire logic clock,
    input wire logic resetn,
    input wire logic shared_port_pin,
    output logic low_speed_osc,
    output logic high_speed_osc,
    output int pin_falls
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] div_q;
    logic pin_q;
    logic port_data_bit, port_pin_hiz_ctrl, pin_seen;
    // port latch kept at 1 and driven, so only the wave reaches the pin
    assign port_data_bit = 1'b1;
    assign port_pin_hiz_ctrl = 1'b0;
    assign pin_seen = port_pin_hiz_ctrl | (port_data_bit & shared_port_pin);
    // fast source is stable from reset, long before any start
    assign high_speed_osc = 1'b1;
    assign low_speed_osc = (div_q == 2'h3);
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            div_q <= 2'h0;
            pin_q <= 1'b1;
            pin_falls <= 0;
        end else begin
            div_q <= div_q + 2'h1;
            pin_q <= pin_seen;
            if (pin_q && !pin_seen) begin
                pin_falls <= pin_falls + 1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== testbench/test_dual_8bit_programmable_timer.sv ====
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
    mismatches++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module test_dual_8bit_programmable_timer;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic ls, hs, irq, wave, pin, ser, mode_sel = 1'b0, sel = 1'b0, oe = 1'b0;
    d8pt_pkg::d8pt_chan_ctrl_s ctl [2] = '{'0, '0};
    logic msk [2] = '{1'b0, 1'b0};
    logic clr [2] = '{1'b0, 1'b0};
    logic rdl [2] = '{1'b0, 1'b0};
    logic flg [2];
    logic [3:0] lo [2];
    logic [3:0] hi [2];
    int mismatches = 0, check_count = 0, falls, n, d;
    d8pt_pkg::d8pt_byte_t v, w;
    always #50 clock = ~clock;
    d8pt_timer d8pt_timer_i (.clock(clock), .resetn(resetn),
        .low_speed_osc(ls), .high_speed_osc(hs), .t0_ctrl(ctl[0]),
        .t1_ctrl(ctl[1]), .t0_counter_mode_sel(mode_sel),
        .t0_irq_mask(msk[0]), .t1_irq_mask(msk[1]),
        .wave_channel_select(sel), .wave_output_enable(oe),
        .t0_flag_clear(clr[0]), .t1_flag_clear(clr[1]),
        .t0_read_low(rdl[0]), .t1_read_low(rdl[1]),
        .t0_count_readback_lo(lo[0]), .t0_count_readback_hi(hi[0]),
        .t1_count_readback_lo(lo[1]), .t1_count_readback_hi(hi[1]),
        .t0_underflow_flag(flg[0]), .t1_underflow_flag(flg[1]),
        .irq(irq), .square_wave_signal(wave), .shared_port_pin(pin),
        .serial_clock_pulse(ser));
    d8pt_partner d8pt_partner_i (.clock(clock), .resetn(resetn),
        .shared_port_pin(pin), .low_speed_osc(ls), .high_speed_osc(hs),
        .pin_falls(falls));
    task automatic tick(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask
    task automatic cfg(input int c, input logic r, input logic s,
                       input logic [1:0] q);
        @(posedge clock);
        ctl[c].run_bit <= r;
        ctl[c].source_select <= s;
        ctl[c].ratio <= q;
    endtask
    task automatic preset(input int c, input d8pt_pkg::d8pt_byte_t x);
        @(posedge clock);
        ctl[c].reload_value <= x;
        ctl[c].reload_strobe <= 1'b1;
        @(posedge clock);
        ctl[c].reload_strobe <= 1'b0;
        tick(2);
    endtask
    task automatic pulse_rdl(input int c);
        @(posedge clock);
        rdl[c] <= 1'b1;
        @(posedge clock);
        rdl[c] <= 1'b0;
        tick(2);
    endtask
    task automatic rd(input int c, output d8pt_pkg::d8pt_byte_t x);
        pulse_rdl(c);
        x = {hi[c], lo[c]};
    endtask
    // third toggle gap; earlier ones may carry prescaler leftovers
    task automatic gap(output int k);
        logic o;
        repeat (3) begin
            o = wave;
            k = 0;
            while (wave === o && k < 3000) begin
                tick(1);
                k++;
            end
        end
    endtask
    task automatic t_reset;
        `CHK("flag0", 1'b0, flg[0])
        `CHK("irq", 1'b0, irq)
        `CHK("pin", 1'b1, pin)
        $display("reset done");
    endtask
    task automatic t_load_hold;
        preset(0, 8'ha5);
        rd(0, v);
        `CHK("preset", 8'ha5, v)
        cfg(0, 1'b1, 1'b1, 2'h0);
        tick(10);
        cfg(0, 1'b0, 1'b1, 2'h0);
        tick(3);
        rd(0, v);
        `CHK("moved", 1'b1, v < 8'ha5 && v > 8'h98)
        tick(20);
        rd(0, w);
        `CHK("held", v, w)
        $display("load hold done");
    endtask
    task automatic t_latch;
        preset(0, 8'h10);
        pulse_rdl(0);
        cfg(0, 1'b1, 1'b1, 2'h0);
        tick(6);
        `CHK("latched hi", 4'h1, hi[0])
        cfg(0, 1'b0, 1'b1, 2'h0);
        rd(0, v);
        `CHK("new hi", 4'h0, v[7:4])
        $display("latch done");
    endtask
    task automatic t_period;
        int dv [4] = '{1, 4, 32, 256};
        preset(0, 8'h01);
        for (int r = 0; r < 4; r++) begin
            cfg(0, 1'b1, 1'b1, r[1:0]);
            gap(n);
            `CHK("t0 gap", 2 * dv[r], n)
        end
        preset(1, 8'h03);
        cfg(1, 1'b1, 1'b0, 2'h0);
        @(posedge clock);
        sel <= 1'b1;
        gap(n);
        `CHK("t1 slow gap", 16, n)
        $display("period done");
    endtask
    task automatic t_irq;
        `CHK("flag1 masked", 1'b1, flg[1])
        `CHK("irq masked", 1'b0, irq)
        @(posedge clock);
        msk[1] <= 1'b1;
        tick(3);
        `CHK("irq on", 1'b1, irq)
        cfg(0, 1'b0, 1'b1, 2'h0);
        cfg(1, 1'b0, 1'b0, 2'h0);
        clr[0] <= 1'b1;
        clr[1] <= 1'b1;
        @(posedge clock);
        clr[0] <= 1'b0;
        clr[1] <= 1'b0;
        tick(3);
        `CHK("flag1 clr", 1'b0, flg[1])
        `CHK("irq off", 1'b0, irq)
        $display("irq done");
    endtask
    task automatic t_pin;
        preset(1, 8'h01);
        cfg(1, 1'b1, 1'b1, 2'h0);
        d = falls;
        n = 0;
        for (int i = 0; i < 40; i++) begin
            tick(1);
            n += (ser === 1'b1);
        end
        `CHK("pin idle", 1'b1, pin)
        `CHK("no falls", d, falls)
        `CHK("serial", 20, n)
        @(posedge clock);
        oe <= 1'b1;
        tick(50);
        d = falls - d;
        `CHK("falls", 1'b1, d >= 12 && d <= 13)
        $display("pin done");
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clock);
        resetn <= 1'b1;
        tick(2);
        t_reset();
        t_load_hold();
        t_latch();
        t_period();
        t_irq();
        t_pin();
        final_report();
    end
    initial begin
        repeat (30000) @(posedge clock);
        mismatches++;
        final_report();
    end
endmodule
`default_nettype wire
